// file: src/fpbi_defs.vh
// constants for the flash parallel bus interface block
`ifndef FPBI_DEFS_VH
`define FPBI_DEFS_VH

// bus operation codes, one-hot
`define FPBI_OP_RESET      6'h01
`define FPBI_OP_STANDBY    6'h02
`define FPBI_OP_OUTDIS     6'h04
`define FPBI_OP_ASYNC_RD   6'h08
`define FPBI_OP_SYNC_RD    6'h10
`define FPBI_OP_WRITE      6'h20

// address layout: 0x20000 words per block, 8 partitions at top bits
`define FPBI_BLK_SHIFT     17
`define FPBI_PART_BITS     3
`define FPBI_DATA_W        16
`define FPBI_MUX_HI_LSB    16

// recovery time after reset release, in ns
`define FPBI_RECOV_NS      100
`define FPBI_CLK_NS        8

// one-hot burst states
`define FPBI_ST_IDLE       3'h1
`define FPBI_ST_LAT        3'h2
`define FPBI_ST_BURST      3'h4

// background program/erase busy time in cycles (model of the array)
`define FPBI_BUSY_CYC      16'h0100

`endif

// file: src/fpbi_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fpbi_sync3 #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input  wire ref_clk_i,
   input  wire sys_rst_i,
   // async input and filtered level
   input  wire async_i,
   output wire level_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg lvl_q;

   // =========================================
   // sampling
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // only a settled value counts
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign level_o = lvl_q;
endmodule

// file: src/fpbi_core.v
// flash parallel bus interface, device end of the host bus
`timescale 1ns/1ps
`include "fpbi_defs.vh"
module fpbi_core #(
   parameter ADDR_W    = 27,
   parameter MUXED     = 0,
   parameter LATENCY   = 4,
   parameter BURST_LEN = 8,
   parameter [15:0] ID_SEP = 16'hA5C0,  // arbitrary identifier value
   parameter [15:0] ID_MUX = 16'hA5C1   // arbitrary identifier value
) (
   // clock and reset
   input  wire              ref_clk_i,
   input  wire              sys_rst_i,
   // host control pins
   input  wire              rst_n_i,
   input  wire              chip_sel_n_i,
   input  wire              out_en_n_i,
   input  wire              wr_en_n_i,
   input  wire              address_valid_n_i,
   input  wire              wr_prot_n_i,
   input  wire              burst_clk_i,
   input  wire              sync_mode_i,
   input  wire              wait_pol_i,
   // address pins
   input  wire [ADDR_W-1:0] addr_i,
   // data pins, three-signal form
   input  wire [15:0]       dq_i,
   output reg  [15:0]       dq_o,
   output wire              dq_oe_o,
   output wire              wait_o,
   output wire              wait_oe_o,
   // user side towards the array
   input  wire [15:0]       rd_data_i,
   input  wire              id_read_i,
   output reg  [ADDR_W-1:0] cur_addr_o,
   output reg  [ADDR_W-18:0] block_o,
   output reg  [2:0]        part_o,
   output reg               wr_stb_o,
   output reg  [15:0]       wr_data_o,
   output wire              lockdown_en_o,
   output reg               pe_busy_o,
   output reg               pe_abort_o,
   output wire [5:0]        bus_op_o
);
   localparam integer RECOV_CYC =
      (`FPBI_RECOV_NS + `FPBI_CLK_NS - 1) / `FPBI_CLK_NS;

   // =========================================
   // synchronised pins
   wire rst_n_s;
   wire cs_n_s;
   wire oe_n_s;
   wire we_n_s;
   wire adv_n_s;
   wire wp_n_s;
   wire clk_s;

   fpbi_sync3 #(.RST_VAL(1'b0)) u_rst (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (rst_n_i),   .level_o   (rst_n_s));
   fpbi_sync3 #(.RST_VAL(1'b1)) u_cs (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (chip_sel_n_i), .level_o (cs_n_s));
   fpbi_sync3 #(.RST_VAL(1'b1)) u_oe (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (out_en_n_i), .level_o  (oe_n_s));
   fpbi_sync3 #(.RST_VAL(1'b1)) u_we (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (wr_en_n_i), .level_o   (we_n_s));
   fpbi_sync3 #(.RST_VAL(1'b1)) u_adv (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (address_valid_n_i), .level_o (adv_n_s));
   fpbi_sync3 #(.RST_VAL(1'b1)) u_wp (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (wr_prot_n_i), .level_o (wp_n_s));
   fpbi_sync3 #(.RST_VAL(1'b0)) u_clk (
      .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
      .async_i   (burst_clk_i), .level_o (clk_s));

   // address and data sampled three deep, one stage short of the filtered strobes
   reg [ADDR_W-1:0] a1_q;
   reg [ADDR_W-1:0] a2_q;
   reg [ADDR_W-1:0] a3_q;
   reg [15:0]       d1_q;
   reg [15:0]       d2_q;
   reg [15:0]       d3_q;
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         a1_q <= {ADDR_W{1'b0}};
         a2_q <= {ADDR_W{1'b0}};
         a3_q <= {ADDR_W{1'b0}};
         d1_q <= 16'h0000;
         d2_q <= 16'h0000;
         d3_q <= 16'h0000;
      end else begin
         a1_q <= addr_i;
         a2_q <= a1_q;
         a3_q <= a2_q;
         d1_q <= dq_i;
         d2_q <= d1_q;
         d3_q <= d2_q;
      end
   end

   // lower address comes off the shared bus in the multiplexed variant
   wire [ADDR_W-1:0] pin_addr;
   generate
      if (MUXED != 0) begin : g_mux
         assign pin_addr = {a3_q[ADDR_W-1:`FPBI_MUX_HI_LSB], d3_q};
      end else begin : g_sep
         assign pin_addr = a3_q;
      end
   endgenerate

   // =========================================
   // edge detection and recovery window
   reg adv_n_q;
   reg clk_q;
   reg we_n_q;
   reg cs_n_q;
   reg [7:0] recov_q;
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         adv_n_q <= 1'b1;
         clk_q   <= 1'b0;
         we_n_q  <= 1'b1;
         cs_n_q  <= 1'b1;
         recov_q <= 8'h00;
      end else begin
         adv_n_q <= adv_n_s;
         clk_q   <= clk_s;
         we_n_q  <= we_n_s;
         cs_n_q  <= cs_n_s;
         // the host must not cycle the bus yet; the device stays idle
         if (!rst_n_s) begin
            recov_q <= RECOV_CYC[7:0];
         end else if (recov_q != 8'h00) begin
            recov_q <= recov_q - 8'h01;
         end
      end
   end

   wire active   = rst_n_s && (recov_q == 8'h00);
   wire adv_rise = adv_n_s && !adv_n_q;
   wire clk_rise = clk_s && !clk_q;
   wire wr_end   = (we_n_s && !we_n_q) || (cs_n_s && !cs_n_q);

   // =========================================
   // bus operation decode
   reg [5:0] op;
   always @* begin
      if (!rst_n_s) begin
         op = `FPBI_OP_RESET;
      end else if (cs_n_s) begin
         op = `FPBI_OP_STANDBY;
      end else if (!we_n_s && oe_n_s) begin
         op = `FPBI_OP_WRITE;
      end else if (oe_n_s) begin
         op = `FPBI_OP_OUTDIS;
      end else if (!we_n_s) begin
         op = `FPBI_OP_OUTDIS;
      end else if (sync_mode_i) begin
         op = `FPBI_OP_SYNC_RD;
      end else begin
         op = `FPBI_OP_ASYNC_RD;
      end
   end
   assign bus_op_o = op;

   wire rd_op = (op == `FPBI_OP_ASYNC_RD) || (op == `FPBI_OP_SYNC_RD);

   // =========================================
   // address capture, burst engine, write strobe
   reg [2:0] st_q;
   reg [7:0] cnt_q;
   reg       dvalid_q;
   reg       wr_pend_q;
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q       <= `FPBI_ST_IDLE;
         cnt_q      <= 8'h00;
         dvalid_q   <= 1'b0;
         cur_addr_o <= {ADDR_W{1'b0}};
         wr_pend_q  <= 1'b0;
         wr_stb_o   <= 1'b0;
         wr_data_o  <= 16'h0000;
      end else if (!active) begin
         st_q      <= `FPBI_ST_IDLE;
         dvalid_q  <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_stb_o  <= 1'b0;
      end else begin
         wr_stb_o <= 1'b0;
         // async access: address flows while the strobe is low
         if (!adv_n_s && !sync_mode_i) begin
            cur_addr_o <= pin_addr;
         end
         if (op == `FPBI_OP_WRITE) begin
            wr_pend_q <= 1'b1;
            if (!adv_n_s) begin
               cur_addr_o <= pin_addr;
            end
            wr_data_o <= d3_q;
         end
         // data taken on the first rising edge of write enable or select
         if (wr_pend_q && wr_end) begin
            wr_pend_q <= 1'b0;
            wr_stb_o  <= 1'b1;
         end
         case (st_q)
            `FPBI_ST_IDLE: begin
               dvalid_q <= (op == `FPBI_OP_ASYNC_RD);
               if (op == `FPBI_OP_SYNC_RD && adv_rise) begin
                  cur_addr_o <= pin_addr;
                  cnt_q      <= LATENCY[7:0];
                  st_q       <= `FPBI_ST_LAT;
               end
            end
            `FPBI_ST_LAT: begin
               dvalid_q <= 1'b0;
               if (!rd_op) begin
                  st_q <= `FPBI_ST_IDLE;
               end else if (clk_rise) begin
                  if (cnt_q == 8'h01) begin
                     cnt_q    <= BURST_LEN[7:0];
                     dvalid_q <= 1'b1;
                     st_q     <= `FPBI_ST_BURST;
                  end else begin
                     cnt_q <= cnt_q - 8'h01;
                  end
               end
            end
            `FPBI_ST_BURST: begin
               if (!rd_op) begin
                  st_q     <= `FPBI_ST_IDLE;
                  dvalid_q <= 1'b0;
               end else if (clk_rise) begin
                  if (cnt_q == 8'h01) begin
                     dvalid_q <= 1'b0;
                     st_q     <= `FPBI_ST_IDLE;
                  end else begin
                     cnt_q      <= cnt_q - 8'h01;
                     cur_addr_o <= cur_addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: begin
               st_q <= `FPBI_ST_IDLE;
            end
         endcase
      end
   end

   // =========================================
   // read data, identifier, block decode
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dq_o    <= 16'h0000;
         block_o <= {(ADDR_W-17){1'b0}};
         part_o  <= 3'h0;
      end else begin
         if (id_read_i) begin
            dq_o <= (MUXED != 0) ? ID_MUX : ID_SEP;
         end else begin
            dq_o <= rd_data_i;
         end
         block_o <= cur_addr_o[ADDR_W-1:`FPBI_BLK_SHIFT];
         part_o  <= cur_addr_o[ADDR_W-1:ADDR_W-`FPBI_PART_BITS];
      end
   end

   // pins are driven only while reading
   assign dq_oe_o = active && rd_op;
   // wait floats with the data bus except when muxed and merely disabled
   assign wait_oe_o = active && (rd_op ||
                      ((MUXED != 0) && op == `FPBI_OP_OUTDIS));
   assign wait_o = (rd_op && !dvalid_q) ? wait_pol_i : !wait_pol_i;
   assign lockdown_en_o = !wp_n_s;

   // =========================================
   // background program/erase, aborted by the reset pin
   reg [15:0] busy_q;
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_q     <= 16'h0000;
         pe_busy_o  <= 1'b0;
         pe_abort_o <= 1'b0;
      end else begin
         pe_abort_o <= 1'b0;
         if (!rst_n_s) begin
            if (pe_busy_o) begin
               pe_abort_o <= 1'b1;
            end
            pe_busy_o <= 1'b0;
            busy_q    <= 16'h0000;
         end else if (wr_stb_o && !pe_busy_o) begin
            pe_busy_o <= 1'b1;
            busy_q    <= `FPBI_BUSY_CYC;
         end else if (pe_busy_o) begin
            // standby does not stop it
            if (busy_q == 16'h0001) begin
               pe_busy_o <= 1'b0;
            end
            busy_q <= busy_q - 16'h0001;
         end
      end
   end
endmodule

// file: dv/fpbi_checker.sv
// port assertions for the flash bus block
`timescale 1ns/1ps
`include "fpbi_defs.vh"
module fpbi_checker #(
   parameter ADDR_W = 27
) (
   // clock and reset
   input wire               ref_clk_i,
   input wire               sys_rst_i,
   // pins in
   input wire               rst_n_i,
   input wire               wr_prot_n_i,
   input wire               wait_pol_i,
   // outputs
   input wire               dq_oe_o,
   input wire               wait_o,
   input wire               wait_oe_o,
   input wire [ADDR_W-1:0]  cur_addr_o,
   input wire [ADDR_W-18:0] block_o,
   input wire [2:0]         part_o,
   input wire               wr_stb_o,
   input wire               lockdown_en_o,
   input wire               pe_busy_o,
   input wire               pe_abort_o,
   input wire [5:0]         bus_op_o
);
   // ====
   // properties
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   wire rd_op = bus_op_o == `FPBI_OP_ASYNC_RD || bus_op_o == `FPBI_OP_SYNC_RD;
   sequence s_wr_end;
      bus_op_o == `FPBI_OP_WRITE ##1 (bus_op_o == `FPBI_OP_OUTDIS
         || bus_op_o == `FPBI_OP_STANDBY);
   endsequence
   sequence s_lock_low;
      (rst_n_i && !wr_prot_n_i) [*8];
   endsequence
   a_reset_floats:
      assert property (bus_op_o == `FPBI_OP_RESET |-> !dq_oe_o && !wait_oe_o)
         else $error("output driven in reset");
   a_drive_read:
      assert property (dq_oe_o |-> rd_op) else $error("bus driven off read");
   a_op_onehot:
      assert property ($onehot(bus_op_o)) else $error("bus op not one-hot");
   a_lock_on:
      assert property (s_lock_low |-> lockdown_en_o) else $error("lock off");
   a_lock_off:
      assert property ((rst_n_i && wr_prot_n_i) [*8] |-> !lockdown_en_o)
         else $error("lock on");
   a_wait_idle:
      assert property (wait_oe_o && !dq_oe_o |-> wait_o != wait_pol_i)
         else $error("wait not deasserted while data floats");
   a_write_strobe:
      assert property (s_wr_end |-> ##[0:3] wr_stb_o)
         else $error("write end without strobe");
   a_busy_after:
      assert property (wr_stb_o |=> !wr_stb_o && pe_busy_o)
         else $error("strobe not single or busy missing");
   a_abort_clear:
      assert property (pe_abort_o |-> $past(pe_busy_o) ##1
         (!pe_abort_o && !pe_busy_o)) else $error("abort pulse wrong");
   a_block_index:
      assert property ($stable(cur_addr_o) [*2] |->
         block_o == cur_addr_o[ADDR_W-1:17]
         && part_o == cur_addr_o[ADDR_W-1:ADDR_W-3])
         else $error("block or partition decode wrong");
endmodule

bind fpbi_core fpbi_checker #(.ADDR_W(ADDR_W)) u_chk (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .rst_n_i(rst_n_i),
   .wr_prot_n_i(wr_prot_n_i), .wait_pol_i(wait_pol_i), .dq_oe_o(dq_oe_o),
   .wait_o(wait_o), .wait_oe_o(wait_oe_o), .cur_addr_o(cur_addr_o),
   .block_o(block_o), .part_o(part_o), .wr_stb_o(wr_stb_o),
   .lockdown_en_o(lockdown_en_o), .pe_busy_o(pe_busy_o),
   .pe_abort_o(pe_abort_o), .bus_op_o(bus_op_o));

// file: dv/fpbi_host_model.sv
// host controller model driving the flash bus pins
`timescale 1ns/1ps
module fpbi_host_model #(
   parameter AW = 27
) (
   // clock and device data side
   input  wire          clk_i,
   input  wire [15:0]   dev_dq_i,
   input  wire          dev_oe_i,
   // pins towards the device
   output logic          rst_n_o,
   output logic          cs_n_o,
   output logic          oe_n_o,
   output logic          we_n_o,
   output logic          adv_n_o,
   output logic          bclk_o,
   output logic [AW-1:0] addr_o,
   output wire  [15:0]   bus_o
);
   // ====
   // bus level and pin tasks
   logic        hoe = 0;
   logic [15:0] hd = 16'h0000;
   logic [15:0] last = 16'h0000;
   // a released bus shows the inverse of its last level, never a stale copy
   assign bus_o = dev_oe_i ? dev_dq_i : hoe ? hd : ~last;
   always @(posedge clk_i) last <= bus_o;
   initial begin
      rst_n_o = 1;
      bclk_o = 0;
      addr_o = '0;
      pin(1, 1, 1, 1);
   end
   task automatic cyc(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pin(logic c, logic o, logic w, logic a);
      cs_n_o = c;
      oe_n_o = o;
      we_n_o = w;
      adv_n_o = a;
   endtask
   task automatic rstp(logic v);
      rst_n_o = v;
      if (v) cyc(20);
   endtask
   task automatic wr(logic [AW-1:0] a, logic [15:0] d);
      addr_o = a;
      hd = d;
      hoe = 1;
      pin(0, 1, 1, 0);
      cyc(1);
      we_n_o = 0;
      cyc(8);
      we_n_o = 1;
      // data and address held until the device has seen the rise
      cyc(6);
      pin(1, 1, 1, 1);
      hoe = 0;
      cyc(1);
   endtask
   task automatic rd(logic [AW-1:0] a);
      addr_o = a;
      pin(0, 0, 1, 0);
   endtask
   // burst clock only runs inside a frame
   task automatic tick();
      bclk_o = 1;
      #80;
      bclk_o = 0;
      #80;
   endtask
endmodule

// file: dv/fpbi_tb_top.sv
// self-checking bench for the flash bus block
`timescale 1ns/1ps
`include "fpbi_defs.vh"
module fpbi_tb_top;
   localparam AW = 27;
   localparam BL = 8;
   localparam LAT = 4;
   localparam [15:0] ID = 16'h3C5A; // arbitrary identifier value
   localparam [15:0] IDM = 16'h3C5B; // arbitrary identifier value
   logic ref_clk_i = 0, sys_rst_i = 1, sync_mode_i = 0, wait_pol_i = 0;
   logic wr_prot_n_i = 1, id_read_i = 0;
   wire rst_n, cs_n, oe_n, we_n, adv_n, bclk, dq_oe, wt, wt_oe, stb, lk;
   wire busy, abrt, wt_mx, wt_oe_mx;
   wire [AW-1:0] addr, cur, cur_mx;
   wire [15:0] bus, dq, wd, rdd, dq_mx;
   wire [5:0] op;
   wire [AW-18:0] blk;
   wire [2:0] part;
   int miscompares = 0, checks_done = 0, cycles = 0, nstb = 0, nab = 0;
   int i, k, n;
   logic [AW-1:0] a, sa, sam;
   logic [15:0] d, sd;
   // ====
   // array model and checks
   function automatic [15:0] mem(input [AW-1:0] x);
      return x[15:0] ^ {5'h00, x[26:16]} ^ 16'h5A3C;
   endfunction
   assign rdd = mem(cur);
   always #4 ref_clk_i = ~ref_clk_i;
   fpbi_host_model #(.AW(AW)) host (.clk_i(ref_clk_i), .dev_dq_i(dq),
      .dev_oe_i(dq_oe), .rst_n_o(rst_n), .cs_n_o(cs_n), .oe_n_o(oe_n),
      .we_n_o(we_n), .adv_n_o(adv_n), .bclk_o(bclk), .addr_o(addr),
      .bus_o(bus));
   fpbi_core #(.LATENCY(LAT), .BURST_LEN(BL), .ID_SEP(ID)) dut (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .rst_n_i(rst_n),
      .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .wr_en_n_i(we_n),
      .address_valid_n_i(adv_n), .wr_prot_n_i(wr_prot_n_i),
      .burst_clk_i(bclk), .sync_mode_i(sync_mode_i),
      .wait_pol_i(wait_pol_i), .addr_i(addr), .dq_i(bus), .dq_o(dq),
      .dq_oe_o(dq_oe), .wait_o(wt), .wait_oe_o(wt_oe), .rd_data_i(rdd),
      .id_read_i(id_read_i), .cur_addr_o(cur), .block_o(blk),
      .part_o(part), .wr_stb_o(stb), .wr_data_o(wd), .lockdown_en_o(lk),
      .pe_busy_o(busy), .pe_abort_o(abrt), .bus_op_o(op));
   // second device in the multiplexed variant on the same host pins
   fpbi_core #(.MUXED(1), .LATENCY(LAT), .BURST_LEN(BL), .ID_MUX(IDM)) dut_mx (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .rst_n_i(rst_n),
      .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .wr_en_n_i(we_n),
      .address_valid_n_i(adv_n), .wr_prot_n_i(wr_prot_n_i),
      .burst_clk_i(bclk), .sync_mode_i(sync_mode_i),
      .wait_pol_i(wait_pol_i), .addr_i(addr), .dq_i(bus), .dq_o(dq_mx),
      .dq_oe_o(), .wait_o(wt_mx), .wait_oe_o(wt_oe_mx), .rd_data_i(rdd),
      .id_read_i(id_read_i), .cur_addr_o(cur_mx), .block_o(), .part_o(),
      .wr_stb_o(), .wr_data_o(), .lockdown_en_o(), .pe_busy_o(),
      .pe_abort_o(), .bus_op_o());
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      if (stb === 1) begin
         nstb <= nstb + 1;
         sd <= wd;
         sa <= cur;
         // both devices see the same pins, so their strobes coincide
         sam <= cur_mx;
      end
      if (abrt === 1) nab <= nab + 1;
      cycles <= cycles + 1;
      if (cycles > 30000) begin
         miscompares++;
         final_report();
      end
   end
   // ====
   // main sequence
   initial begin
      void'($urandom(97));
      host.cyc(3);
      sys_rst_i = 0;
      host.cyc(20);
      for (k = 0; k < 6; k++) begin
         a = (k == 0) ? '0 : (k == 1) ? '1 : AW'($urandom);
         d = 16'($urandom);
         n = nstb;
         host.wr(a, d);
         chk("strobes", n + 1, nstb);
         chk("wdata", d, sd);
         chk("waddr", a, sa);
         chk("mux addr", {a[AW-1:16], d}, sam);
         chk("block", a[AW-1:17], blk);
         chk("part", a[AW-1:AW-3], part);
         chk("busy", 1, busy);
         host.rd(a ^ 27'h0000001);
         for (i = 0; i < 20 && dq_oe !== 1; i++) host.cyc(1);
         host.cyc(3);
         chk("rdata", mem(a ^ 27'h0000001), dq);
         id_read_i = 1;
         host.cyc(3);
         chk("ident", ID, dq);
         chk("ident mux", IDM, dq_mx);
         id_read_i = 0;
         host.pin(1, 0, 1, 0);
         host.cyc(8);
         chk("standby", `FPBI_OP_STANDBY, op);
         chk("float", 0, dq_oe);
         host.pin(0, 1, 1, 1);
         host.cyc(8);
         chk("outdis", `FPBI_OP_OUTDIS, op);
         chk("wait float", 0, wt_oe);
         chk("wait mux", {1'b1, !wait_pol_i}, {wt_oe_mx, wt_mx});
         host.pin(1, 1, 1, 1);
         // let the deselect settle before the next write starts
         host.cyc(4);
         for (i = 0; i < 300 && busy !== 0; i++) host.cyc(1);
      end
      $display("end writes and reads");
      for (k = 0; k < 2; k++) begin
         wait_pol_i = k[0];
         sync_mode_i = 1;
         a = AW'($urandom);
         host.rd(a);
         host.cyc(6);
         host.pin(0, 0, 1, 1);
         host.cyc(6);
         n = 0;
         repeat (LAT + BL + 3) begin
            host.tick();
            if (wt !== k) begin
               if (n == 0) chk("burst first", mem(a), dq);
               n++;
            end
         end
         chk("burst words", BL, n);
         chk("wait after", k, wt);
         host.pin(1, 1, 1, 1);
         sync_mode_i = 0;
         host.cyc(8);
      end
      $display("end bursts");
      n = nab;
      host.wr(AW'($urandom), 16'($urandom));
      host.rstp(0);
      host.cyc(8);
      chk("abort", n + 1, nab);
      chk("reset op", `FPBI_OP_RESET, op);
      host.rd(a);
      host.cyc(8);
      chk("reset float", 0, dq_oe);
      host.pin(1, 1, 1, 1);
      host.rstp(1);
      chk("busy gone", 0, busy);
      $display("end pin reset");
      for (k = 0; k < 4; k++) begin
         wr_prot_n_i = (k == 0) ? 1'b0 : 1'($urandom);
         host.cyc(10);
         chk("lockdown", !wr_prot_n_i, lk);
      end
      $display("end lockdown");
      final_report();
   end
endmodule
